// ==== logic/sub_borrow_params.svh ====
// Constants for the subtract-with-borrow datapath.
// Assumes inclusion by bare name from the package and the datapath module.
`ifndef SUB_BORROW_PARAMS_SVH
`define SUB_BORROW_PARAMS_SVH

`define OPC_HI_MSB       15
`define OPC_HI_LSB       10
`define OPC_SUBB         6'h16
`define DEST_BIT         9
`define BANK_BIT         8
`define ADDR_MSB         7
`define IDX_LIMIT        8'h5F
`define ACC_HI_BANK      4'hF
`define ACC_SPLIT        8'h60
`define STATUS_N         4
`define STATUS_SRANGE    3
`define STATUS_Z         2
`define STATUS_NIBC      1
`define STATUS_C         0
`define BYTE_ZERO        8'h00
`define INSTR_ZERO       16'h0000
`define ADDR_ZERO        12'h000
`define STATUS_ZERO      5'h00

`endif

// ==== logic/sub_borrow_pkg.sv ====
// Types for the subtract-with-borrow datapath.
// Assumes the params header is on the include path.
`include "sub_borrow_params.svh"

package sub_borrow_pkg;

    // One-hot instruction phases
    typedef enum logic [3:0] {
        PH_DECODE  = 4'h1,
        PH_READ    = 4'h2,
        PH_PROCESS = 4'h4,
        PH_WRITE   = 4'h8
    } phase_t;

    // How the operand address was resolved
    typedef enum logic [2:0] {
        MODE_ACCESS  = 3'h1,
        MODE_BANKED  = 3'h2,
        MODE_INDEXED = 3'h4
    } addr_mode_t;

endpackage : sub_borrow_pkg

// ==== logic/subtract_borrow_datapath.sv ====
// Execution datapath for the subtract-accumulator-with-borrow instruction.
// Assumes a data memory with combinational read and write-enable port,
// and a core that holds instr_valid_i high until done_o pulses.
// The accumulator input is read live in the write phase, so the core must
// keep it steady from accept until done_o.
// Only the subtract-with-borrow opcode executes; any other word is flagged
// illegal after the read phase and writes nothing.
// The extended-set enable is sampled in the read phase, not at accept, so it
// must not change while an instruction is in flight.
// Bank pointer and index base are read in the read phase for the same reason.
// Limitation: no stall input; a slow memory cannot hold the operand read.
// Flags are written on every executed subtract, whatever the destination.
`timescale 1ns/10ps
`include "sub_borrow_params.svh"

module subtract_borrow_datapath (
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    instr_valid_i,
    input  wire logic [15:0]             instr_i,
    input  wire logic                    ext_set_en_i,
    input  wire logic [3:0]              bank_pointer_i,
    input  wire logic [11:0]             index_base_i,
    input  wire logic [7:0]              accum_i,
    input  wire logic [4:0]              status_i,
    input  wire logic [7:0]              mem_rdata_i,
    output logic      [11:0]             mem_addr_o,
    output logic                         mem_we_o,
    output logic      [7:0]              mem_wdata_o,
    output logic                         accum_we_o,
    output logic      [7:0]              accum_wdata_o,
    output logic                         status_we_o,
    output logic      [4:0]              status_wdata_o,
    output sub_borrow_pkg::addr_mode_t   addr_mode_o,
    output logic                         illegal_o,
    output logic                         done_o
);
    import sub_borrow_pkg::*;

    // Borrow-style subtract: a + ~b + carry gives a - b - !carry
    function automatic logic [8:0] add_nib(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
        add_nib = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    endfunction : add_nib

    ////////////////////////////////////////////////////////////////////////
    // State
    phase_t         phase_q, phase_d;
    logic [15:0]    instr_q;
    logic [7:0]     opnd_q;
    logic [4:0]     flags_q;
    logic           busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode fields from the captured word
    // The word is held in instr_q, so decode stays stable after instr_i moves
    // The destination bit steers the write strobes, the bank bit the address
    wire            is_subb   = instr_q[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_SUBB;
    wire            dest_mem  = instr_q[`DEST_BIT];
    wire            bank_sel  = instr_q[`BANK_BIT];
    wire [7:0]      faddr     = instr_q[`ADDR_MSB:0];

    // Address resolution; indexed wins over access bank when enabled
    wire            use_idx   = ext_set_en_i && !bank_sel && faddr <= `IDX_LIMIT;
    wire [11:0]     idx_addr  = 12'(index_base_i + {4'h0, faddr});
    wire [11:0]     acc_addr  = (faddr < `ACC_SPLIT) ? {4'h0, faddr}
                                                    : {`ACC_HI_BANK, faddr};
    wire [11:0]     bank_addr = {bank_pointer_i, faddr};
    wire [11:0]     ea        = bank_sel ? bank_addr : (use_idx ? idx_addr : acc_addr);
    wire addr_mode_t ea_mode  = bank_sel ? MODE_BANKED
                              : (use_idx ? MODE_INDEXED : MODE_ACCESS);

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic; both adds reuse one function so the nibble carry matches
    wire            cin       = flags_q[`STATUS_C];
    wire [8:0]      full_sum  = add_nib(opnd_q, accum_i, cin);
    wire [8:0]      lo_sum    = add_nib({4'h0, opnd_q[3:0]}, {4'hF, accum_i[3:0]}, cin);
    wire [7:0]      diff      = full_sum[7:0];
    wire            ovf       = (opnd_q[7] != accum_i[7]) && (diff[7] != opnd_q[7]);
    wire [4:0]      new_flags = {diff[7], ovf, diff == `BYTE_ZERO, lo_sum[4], full_sum[8]};

    ////////////////////////////////////////////////////////////////////////
    // Phase strobes, named once so sequencer and outputs cannot disagree
    // Cycle plan, counted from the accepting edge:
    //   edge 0 decode and capture, edge 1 read and address out,
    //   edge 2 operand capture, edge 3 write, results seen after edge 3.
    //   A foreign opcode ends at edge 1 with only illegal_o and done_o.
    // Everything below keys off these six wires
    wire            accept_now = (phase_q == PH_DECODE) && instr_valid_i && !busy_q;
    wire            read_now   = phase_q == PH_READ;
    wire            proc_now   = phase_q == PH_PROCESS;
    wire            write_now  = phase_q == PH_WRITE;
    wire            reject_now = read_now && !is_subb;
    wire            finish_now = write_now || reject_now;

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencing, one phase per clock
    // Only the decode phase looks at instr_valid_i; the rest run unconditionally
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            PH_DECODE: begin
                if (accept_now) begin
                    phase_d = PH_READ;
                end
            end
            PH_READ: begin
                phase_d = is_subb ? PH_PROCESS : PH_DECODE;
            end
            PH_PROCESS: begin
                phase_d = PH_WRITE;
            end
            PH_WRITE: begin
                phase_d = PH_DECODE;
            end
            default: begin
                phase_d = PH_DECODE;
            end
        endcase
    end

    // Phase register; an illegal one-hot code falls back to decode above
    // Reset parks the sequencer in decode, ready to take a word at once
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_q <= PH_DECODE;
        end else begin
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy covers the cycle in which done_o is high, so a valid still held is not re-taken
    // Costs one idle cycle between instructions; the core drops valid meanwhile
    // Without it the word still on instr_i would run a second time
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= finish_now;
        end
    end

    // Instruction word and carry-in are captured once, at accept
    // Later changes on status_i cannot disturb the running subtract
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            instr_q <= `INSTR_ZERO;
            flags_q <= `STATUS_ZERO;
        end else if (accept_now) begin
            instr_q <= instr_i;
            flags_q <= status_i;
        end
    end

    // Operand read in process phase; memory has seen the address since read
    // A combinational memory is assumed; a registered one would need a stall
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            opnd_q <= `BYTE_ZERO;
        end else if (proc_now) begin
            opnd_q <= mem_rdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and mode outputs, held until the next word reaches read
    // The mode output lets the core see which bank a write went to
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_addr_o  <= `ADDR_ZERO;
            addr_mode_o <= MODE_ACCESS;
        end else if (read_now) begin
            mem_addr_o  <= ea;
            addr_mode_o <= ea_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes pulse for one cycle, the cycle after the write phase; illegal_o and a foreign done_o pulse the cycle after read
    // Registering them costs a cycle of latency but keeps outputs glitch free
    // Done pulses for a foreign opcode too, so the core never waits forever
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_we_o    <= 1'b0;
            accum_we_o  <= 1'b0;
            status_we_o <= 1'b0;
            illegal_o   <= 1'b0;
            done_o      <= 1'b0;
        end else begin
            mem_we_o    <= write_now && dest_mem;
            accum_we_o  <= write_now && !dest_mem;
            status_we_o <= write_now;
            illegal_o   <= reject_now;
            done_o      <= finish_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result and flags hold after the strobe for a consumer that samples late
    // Both data outputs carry the result; the strobe says which one is meant
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_wdata_o    <= `BYTE_ZERO;
            accum_wdata_o  <= `BYTE_ZERO;
            status_wdata_o <= `STATUS_ZERO;
        end else if (write_now) begin
            mem_wdata_o    <= diff;
            accum_wdata_o  <= diff;
            status_wdata_o <= new_flags;
        end
    end

endmodule : subtract_borrow_datapath

// ==== test/subtract_borrow_datapath_asserts.sv ====
// Checker for the subtract-with-borrow datapath, bound to its ports.
// Assumes the testbench holds instr_i steady until done_o is seen.
`timescale 1ns/10ps
`include "sub_borrow_params.svh"
module subtract_borrow_datapath_asserts import sub_borrow_pkg::*; (
    input wire logic       core_clk_i, rst_b_i, instr_valid_i, ext_set_en_i,
    input wire logic [15:0] instr_i,
    input wire logic [3:0] bank_pointer_i,
    input wire logic [11:0] index_base_i,
    input wire logic [7:0] accum_i, mem_rdata_i, mem_wdata_o, accum_wdata_o,
    input wire logic [4:0] status_i, status_wdata_o,
    input wire logic [11:0] mem_addr_o,
    input wire logic       mem_we_o, accum_we_o, status_we_o, illegal_o, done_o,
    input wire addr_mode_t addr_mode_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Result seen by the flag checks follows the selected destination
    wire [7:0] res = mem_we_o ? mem_wdata_o : accum_wdata_o;
    a_done_has_write: assert property (done_o && !illegal_o |-> mem_we_o ^ accum_we_o)
        else $error("done without one write strobe");
    a_done_one_cycle: assert property (done_o |=> !done_o) else $error("done held");
    a_accum_dest: assert property (accum_we_o |-> !instr_i[`DEST_BIT])
        else $error("accumulator written with d set");
    a_mem_dest: assert property (mem_we_o |-> instr_i[`DEST_BIT]) else $error("memory dest");
    a_flags_with_done: assert property (status_we_o == (done_o && !illegal_o))
        else $error("flag strobe out of step");
    a_zero_flag: assert property (status_we_o |-> status_wdata_o[`STATUS_Z] == (res == 8'h00))
        else $error("zero flag wrong");
    a_neg_flag: assert property (status_we_o |-> status_wdata_o[`STATUS_N] == res[7])
        else $error("negative flag wrong");
    a_bank_upper: assert property (addr_mode_o == MODE_BANKED |-> mem_addr_o[11:8] == bank_pointer_i)
        else $error("banked address wrong");
    a_access_low: assert property (addr_mode_o == MODE_ACCESS && mem_addr_o[7:0] < 8'h60 |->
        mem_addr_o[11:8] == 4'h0) else $error("access bank low half wrong");
    a_access_high: assert property (addr_mode_o == MODE_ACCESS && mem_addr_o[7:0] >= 8'h60 |->
        mem_addr_o[11:8] == 4'hF) else $error("access bank high half wrong");
    a_idx_window: assert property (addr_mode_o == MODE_INDEXED |->
        12'(mem_addr_o - index_base_i) <= 12'h05F) else $error("indexed offset too large");
    c_mem: cover property (mem_we_o);
    c_ill: cover property (illegal_o);
    c_acc: cover property (accum_we_o);
    c_idx: cover property (addr_mode_o == MODE_INDEXED);
endmodule : subtract_borrow_datapath_asserts
bind subtract_borrow_datapath subtract_borrow_datapath_asserts u_chk (.*);

// ==== test/test_subtract_with_borrow_datapath.sv ====
// Self-checking bench for the subtract-with-borrow datapath.
// Assumes memory read data is a single held byte from the bench.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module test_subtract_with_borrow_datapath;
    logic core_clk_i = 0, rst_b_i = 0, instr_valid_i = 0, ext_set_en_i = 0;
    logic [15:0] instr_i = 16'h0000;
    logic [3:0] bank_pointer_i = 4'h5;
    logic [11:0] index_base_i = 12'h300, mem_addr_o;
    logic [7:0] accum_i = 8'h00, mem_rdata_i = 8'h00, mem_wdata_o, accum_wdata_o;
    logic [4:0] status_i = 5'h00, status_wdata_o;
    logic mem_we_o, accum_we_o, status_we_o, illegal_o, done_o;
    sub_borrow_pkg::addr_mode_t addr_mode_o;
    int err_total = 0, comparisons = 0;
    logic hung = 1'b0;
    always #5 core_clk_i = ~core_clk_i;
    subtract_borrow_datapath u_dut (.*);
    ////////////////////////////////////////////////////////////////
    // One instruction; outputs read at an edge are the values before it
    task automatic exec(input logic [15:0] ins, input logic [7:0] f, w,
                        input logic c, x, input logic [11:0] ea);
        logic [8:0] r;
        logic [4:0] n;
        logic [4:0] e;
        logic [7:0] got;
        sub_borrow_pkg::addr_mode_t m;
        if (hung) return;
        r = {1'b0, f} - {1'b0, w} - {8'h00, ~c};
        n = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
        e = {r[7], (f[7] ^ w[7]) & (r[7] ^ f[7]), r[7:0] == 8'h00, ~n[4], ~r[8]};
        if (ins[8]) m = sub_borrow_pkg::MODE_BANKED;
        else if (x && ins[7:0] <= 8'h5F) m = sub_borrow_pkg::MODE_INDEXED;
        else m = sub_borrow_pkg::MODE_ACCESS;
        instr_i <= ins;
        accum_i <= w;
        status_i <= {4'h0, c};
        mem_rdata_i <= f;
        ext_set_en_i <= x;
        instr_valid_i <= 1'b1;
        @(posedge core_clk_i);
        for (int i = 0; i < 12 && done_o !== 1'b1; i++) @(posedge core_clk_i);
        `CHK(done_o, 1'b1)
        if (done_o !== 1'b1) hung = 1'b1;
        instr_valid_i <= 1'b0;
        got = ins[9] ? mem_wdata_o : accum_wdata_o;
        if (ins[15:10] != 6'h16) begin
            `CHK({illegal_o, mem_we_o, accum_we_o, status_we_o}, 4'h8)
        end else begin
            `CHK(mem_addr_o, ea)
            `CHK(addr_mode_o, m)
            `CHK(status_wdata_o, e)
            `CHK({mem_we_o, accum_we_o, status_we_o}, {ins[9], ~ins[9], 1'b1})
            `CHK({illegal_o, got}, {1'b0, r[7:0]})
        end
        @(posedge core_clk_i);
        `CHK({done_o, illegal_o, mem_we_o, accum_we_o, status_we_o}, 5'h00)
    endtask : exec
    // Idle values after reset, then a reset cut into a running instruction
    task automatic t_reset;
        `CHK({done_o, illegal_o, mem_we_o, accum_we_o, status_we_o}, 5'h00)
        `CHK({mem_addr_o, mem_wdata_o, accum_wdata_o, status_wdata_o}, 33'h0)
        `CHK(addr_mode_o, sub_borrow_pkg::MODE_ACCESS)
        instr_i <= 16'h5B42;
        accum_i <= 8'h01;
        status_i <= 5'h01;
        mem_rdata_i <= 8'h09;
        instr_valid_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        instr_valid_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        `CHK({done_o, mem_we_o, accum_we_o, status_we_o, mem_addr_o}, 16'h0000)
        rst_b_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        `CHK({done_o, mem_we_o, accum_we_o, status_we_o}, 4'h0)
        $display("reset done");
    endtask : t_reset
    task automatic t_modes;
        exec(16'h5A19, 8'h19, 8'h0D, 1'b1, 1'b0, 12'h019);
        exec(16'h58A0, 8'h1B, 8'h1A, 1'b0, 1'b0, 12'hFA0);
        exec(16'h5B42, 8'h03, 8'h0E, 1'b1, 1'b1, 12'h542);
        exec(16'h585F, 8'h80, 8'h01, 1'b1, 1'b1, 12'h35F);
        exec(16'h5A60, 8'h7F, 8'hFF, 1'b0, 1'b1, 12'hF60);
        $display("modes done");
    endtask : t_modes
    task automatic t_illegal;
        exec(16'h5C00, 8'h01, 8'h01, 1'b1, 1'b0, 12'h000);
        $display("illegal done");
    endtask : t_illegal
    task automatic end_of_test;
        $display("compares %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        t_reset;
        t_modes;
        t_illegal;
        end_of_test;
    end
endmodule : test_subtract_with_borrow_datapath
